// *** hdl/dic_params.svh ***
// named constants for the digital input channel conditioner
// assumes a 100 MHz system clock and a 32-bit avalon-mm register window
`ifndef DIC_PARAMS_SVH
`define DIC_PARAMS_SVH
`define DIC_NCH             8
`define DIC_DLY_W           16
`define DIC_TICK_W          20
`define DIC_ADDR_W          8
`define DIC_CLK_PERIOD_NS   10
`define DIC_MS_TIME_NS      1000000
`define DIC_UPDATE_TIME_US  6500
`define DIC_NS_PER_US       1000
`define DIC_ADDR_CTRL       8'h00
`define DIC_ADDR_MONEN      8'h04
`define DIC_ADDR_INVERT     8'h08
`define DIC_ADDR_SIMEN      8'h0C
`define DIC_ADDR_SIMCFG     8'h10
`define DIC_ADDR_ERRCFG     8'h14
`define DIC_ADDR_SUBVAL     8'h18
`define DIC_ADDR_STATUS     8'h1C
`define DIC_ADDR_TELEGRAM   8'h20
`define DIC_ADDR_ONDLY      8'h40
`define DIC_ADDR_OFFDLY     8'h60
`define DIC_DLY_BLK_MASK    8'hE0
`define DIC_CTRL_EN_BIT     0
`define DIC_SIMSTAT_LSB     8
`define DIC_RST_CTRL        1'h1
`define DIC_RST_MONEN       8'hFF
`define DIC_RST_CFG8        8'h00
`define DIC_RST_ERRCFG      16'h0000
`define DIC_RST_DLY         16'h0000
`endif

// *** hdl/dic_pkg.sv ***
// types shared by the channel conditioner files
// assumes dic_params.svh supplies the numeric constants
package dic_pkg;
  // error strategy per channel, two bits in the error config register
  typedef enum logic [1:0]
  {
    DIC_ERR_CURRENT = 2'h0,  // pass live value
    DIC_ERR_SUBST   = 2'h1,  // replacement value
    DIC_ERR_HOLD    = 2'h3   // last valid value
  } dic_err_mode_t;
  // bus slave sequence, gray coded
  typedef enum logic [0:0]
  {
    DIC_BUS_IDLE = 1'h0,
    DIC_BUS_RESP = 1'h1
  } dic_bus_state_t;
endpackage

// *** hdl/dic_tick_gen.sv ***
// millisecond tick and periodic delivery tick
// assumes the counts are below 2**20 and at least one
`timescale 1ns/10ps
`include "dic_params.svh"
module dic_tick_gen
#(
  parameter int MS_CYCLES  = `DIC_MS_TIME_NS / `DIC_CLK_PERIOD_NS,
  parameter int UPD_CYCLES = (`DIC_UPDATE_TIME_US * `DIC_NS_PER_US) / `DIC_CLK_PERIOD_NS
)
(
  input  wire logic clk,
  input  wire logic sys_rst,
  output logic      msTick,
  output logic      updTick
);
  import dic_pkg::*;

  logic [`DIC_TICK_W-1:0] msCnt_q;   // cycles inside current millisecond
  logic [`DIC_TICK_W-1:0] msCnt_d;
  logic [`DIC_TICK_W-1:0] updCnt_q;  // cycles inside delivery period
  logic [`DIC_TICK_W-1:0] updCnt_d;

  assign msTick   = (msCnt_q == `DIC_TICK_W'(MS_CYCLES - 1));
  assign updTick  = (updCnt_q == `DIC_TICK_W'(UPD_CYCLES - 1));
  assign msCnt_d  = msTick ? '0 : msCnt_q + 1'b1;
  assign updCnt_d = updTick ? '0 : updCnt_q + 1'b1;

  // free running, restarted only by reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      msCnt_q  <= '0;
      updCnt_q <= '0;
    end
    else
    begin
      msCnt_q  <= msCnt_d;
      updCnt_q <= updCnt_d;
    end
  end
endmodule

// *** hdl/dic_delay_filter.sv ***
// on-delay filter and off-delay stretcher for one channel
// assumes msTick is a one-cycle pulse every millisecond
`timescale 1ns/10ps
`include "dic_params.svh"
module dic_delay_filter
(
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 msTick,
  input  wire logic                 rawIn,
  input  wire logic [`DIC_DLY_W-1:0] onDelay,
  input  wire logic [`DIC_DLY_W-1:0] offDelay,
  output logic                      filtOut
);
  import dic_pkg::*;

  logic                  out_q;    // filtered level
  logic [`DIC_DLY_W-1:0] cnt_q;    // elapsed ms since input differed
  logic                  differ;   // input disagrees with output
  logic                  reached;  // pending change has lasted long enough

  assign differ  = rawIn ^ out_q;
  // rising edge waits for on delay, falling edge for off delay
  assign reached = (cnt_q >= (out_q ? offDelay : onDelay));
  assign filtOut = out_q;

  // a bounce back to the old level restarts the wait, so short pulses vanish
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      out_q <= 1'b0;
      cnt_q <= `DIC_RST_DLY;
    end
    else if (!differ)
    begin
      cnt_q <= `DIC_RST_DLY;
    end
    else if (reached)
    begin
      out_q <= rawIn;
      cnt_q <= `DIC_RST_DLY;
    end
    else if (msTick)
    begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule

// *** hdl/dic_conditioner.sv ***
// eight-channel binary input conditioner with avalon-mm registers
// assumes field inputs and fault flags are synchronous to clk,
// and a bus master that holds its request until waitrequest is low
// value, status, fault and telegram outputs move only at the delivery tick; chanActive follows the enable at once
// Behaviour
// - normal mode forwards conditioned live input
// - simulation mode forwards configured simulation bit
// - simulation mode reports configured simulation status
// - pass-live strategy keeps forwarding field input
// - substitution strategy forwards replacement bit during fault
// - replacement value always carries invalid status
// - hold strategy freezes last valid value
// - inversion complements the input bit
// - detected line fault flagged, strategy applied
// - on-delay suppresses short rising pulses
// - off-delay stretches falling transitions
// - channel active follows module-wide enable
// - status bit plus line-fault bit per channel
// - deliver conditioned signals every 6.5 ms
// - disabled line monitoring raises no fault
`timescale 1ns/10ps
`include "dic_params.svh"
module dic_conditioner
#(
  // cycles per millisecond and per delivery period, shortened in simulation
  parameter int MS_CYCLES  = `DIC_MS_TIME_NS / `DIC_CLK_PERIOD_NS,
  parameter int UPD_CYCLES = (`DIC_UPDATE_TIME_US * `DIC_NS_PER_US) / `DIC_CLK_PERIOD_NS
)
(
  // clock and synchronous reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // avalon-mm slave, one wait cycle
  input  wire logic [`DIC_ADDR_W-1:0]   avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  // field front end
  input  wire logic [`DIC_NCH-1:0]      fieldIn,
  input  wire logic [`DIC_NCH-1:0]      lineBreak,
  input  wire logic [`DIC_NCH-1:0]      lineShort,
  // delivery toward the communication unit
  output logic      [`DIC_NCH-1:0]      procValue,
  output logic      [`DIC_NCH-1:0]      procValid,
  output logic      [`DIC_NCH-1:0]      procFault,
  output logic      [`DIC_NCH-1:0]      chanActive,
  output logic      [2*`DIC_NCH-1:0]    telegram,
  output logic                         telegramStrobe
);
  import dic_pkg::*;

  // bus slave state
  dic_bus_state_t busState_q;              // idle or answering
  dic_bus_state_t busState_d;
  logic [31:0]    readData_q;              // answer held during resp cycle
  logic [31:0]    readData_d;

  // configuration registers
  logic                   modEn_q;         // module-wide enable
  logic [`DIC_NCH-1:0]    monEn_q;         // line monitoring per channel
  logic [`DIC_NCH-1:0]    invert_q;        // signal negation per channel
  logic [`DIC_NCH-1:0]    simEn_q;         // simulation mode per channel
  logic [`DIC_NCH-1:0]    simVal_q;        // simulated value
  logic [`DIC_NCH-1:0]    simStat_q;       // simulated status, 1 is data good
  logic [2*`DIC_NCH-1:0]  errCfg_q;        // error strategy, two bits each
  logic [`DIC_NCH-1:0]    subVal_q;        // replacement value
  logic [`DIC_DLY_W-1:0]  onDly_q  [`DIC_NCH];  // on delay in ms
  logic [`DIC_DLY_W-1:0]  offDly_q [`DIC_NCH];  // off delay in ms

  // channel datapath
  logic [`DIC_NCH-1:0]    invIn;           // after negation
  logic [`DIC_NCH-1:0]    filt;            // after delay filters
  logic [`DIC_NCH-1:0]    fault;           // monitored fault
  logic [`DIC_NCH-1:0]    lastValid_q;     // value before the fault
  logic [`DIC_NCH-1:0]    selVal;          // value after selection
  logic [`DIC_NCH-1:0]    selValid;        // status after selection
  logic [`DIC_NCH-1:0]    selFault;        // fault bit after selection
  logic [2*`DIC_NCH-1:0]  telegramNext;    // packed value and fault bits

  // delivered outputs
  logic [`DIC_NCH-1:0]    procValue_q;
  logic [`DIC_NCH-1:0]    procValid_q;
  logic [`DIC_NCH-1:0]    procFault_q;
  logic [2*`DIC_NCH-1:0]  telegram_q;
  logic                   telegramStrobe_q;

  logic msTick;                            // one ms pulse
  logic updTick;                           // delivery period pulse

  // merge write data into a register under the byte enables
  function automatic logic [31:0] beMerge(input logic [31:0] oldVal,
                                          input logic [31:0] newVal,
                                          input logic [3:0]  be);
    logic [31:0] mask;
    mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    beMerge = (oldVal & ~mask) | (newVal & mask);
  endfunction

  // timing base for filters and delivery
  dic_tick_gen
  #(
    .MS_CYCLES  (MS_CYCLES),
    .UPD_CYCLES (UPD_CYCLES)
  )
  u_tick
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .msTick  (msTick),
    .updTick (updTick)
  );

  // bus decode
  // one full compare per single register, a masked compare per delay block
  wire        busReq     = avs_read | avs_write;
  wire        inResp     = (busState_q == DIC_BUS_RESP);
  wire        wrCommit   = inResp & avs_write;   // write lands when waitrequest is low
  wire        hitCtrl    = (avs_address == `DIC_ADDR_CTRL);
  wire        hitMonEn   = (avs_address == `DIC_ADDR_MONEN);
  wire        hitInvert  = (avs_address == `DIC_ADDR_INVERT);
  wire        hitSimEn   = (avs_address == `DIC_ADDR_SIMEN);
  wire        hitSimCfg  = (avs_address == `DIC_ADDR_SIMCFG);
  wire        hitErrCfg  = (avs_address == `DIC_ADDR_ERRCFG);
  wire        hitSubVal  = (avs_address == `DIC_ADDR_SUBVAL);
  wire        hitStatus  = (avs_address == `DIC_ADDR_STATUS);
  wire        hitTele    = (avs_address == `DIC_ADDR_TELEGRAM);
  wire        hitOnDly   = ((avs_address & `DIC_DLY_BLK_MASK) == `DIC_ADDR_ONDLY);
  wire        hitOffDly  = ((avs_address & `DIC_DLY_BLK_MASK) == `DIC_ADDR_OFFDLY);
  wire [2:0]  dlyIdx     = avs_address[4:2];     // word index inside delay block
  wire        wordAlign  = (avs_address[1:0] == 2'h0);

  // write data after byte enables, one per register family
  wire [31:0] wrMerged8  = beMerge(32'h0000_0000, avs_writedata, avs_byteenable);
  // strategy word keeps unselected bytes
  wire [31:0] errMerged  = beMerge({16'h0000, errCfg_q}, avs_writedata, avs_byteenable);

  // one wait cycle on every access, then a single answer cycle
  // fixed latency: no address to readdata path
  assign avs_waitrequest = busReq & ~inResp;
  assign avs_readdata    = readData_q;
  assign busState_d      = (busReq & ~inResp) ? DIC_BUS_RESP : DIC_BUS_IDLE;

  // read mux, unmapped offsets answer zero
  // hit decodes are exclusive, so their order is free; the alignment check must stay first
  always_comb
  begin
    readData_d = 32'h0000_0000;
    if (!wordAlign)
      readData_d = 32'h0000_0000;          // misaligned reads as zero
    else if (hitCtrl)
      readData_d[`DIC_CTRL_EN_BIT] = modEn_q;
    else if (hitMonEn)
      readData_d[`DIC_NCH-1:0] = monEn_q;
    else if (hitInvert)
      readData_d[`DIC_NCH-1:0] = invert_q;
    else if (hitSimEn)
      readData_d[`DIC_NCH-1:0] = simEn_q;
    else if (hitSimCfg)
      readData_d[2*`DIC_NCH-1:0] = {simStat_q, simVal_q};
    else if (hitErrCfg)
      readData_d[2*`DIC_NCH-1:0] = errCfg_q;
    else if (hitSubVal)
      readData_d[`DIC_NCH-1:0] = subVal_q;
    else if (hitStatus)
      readData_d = {chanActive, procFault_q, procValid_q, procValue_q};
    else if (hitTele)
      readData_d[2*`DIC_NCH-1:0] = telegram_q;
    else if (hitOnDly)
      readData_d[`DIC_DLY_W-1:0] = onDly_q[dlyIdx];
    else if (hitOffDly)
      readData_d[`DIC_DLY_W-1:0] = offDly_q[dlyIdx];
  end

  // bus sequence and captured answer
  // answer loads every edge; used in resp only
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      busState_q <= DIC_BUS_IDLE;
      readData_q <= 32'h0000_0000;
    end
    else
    begin
      busState_q <= busState_d;
      readData_q <= readData_d;
    end
  end

  // narrow configuration registers; writes need word alignment
  // unmapped writes fall through unseen
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      modEn_q   <= `DIC_RST_CTRL;
      monEn_q   <= `DIC_RST_MONEN;
      invert_q  <= `DIC_RST_CFG8;
      simEn_q   <= `DIC_RST_CFG8;
      simVal_q  <= `DIC_RST_CFG8;
      simStat_q <= `DIC_RST_CFG8;
      errCfg_q  <= `DIC_RST_ERRCFG;
      subVal_q  <= `DIC_RST_CFG8;
    end
    else if (wrCommit && wordAlign)
    begin
      if (hitCtrl && avs_byteenable[0])
        modEn_q <= avs_writedata[`DIC_CTRL_EN_BIT];
      if (hitMonEn && avs_byteenable[0])
        monEn_q <= wrMerged8[`DIC_NCH-1:0];
      if (hitInvert && avs_byteenable[0])
        invert_q <= wrMerged8[`DIC_NCH-1:0];
      if (hitSimEn && avs_byteenable[0])
        simEn_q <= wrMerged8[`DIC_NCH-1:0];
      // value and status in separate lanes
      if (hitSimCfg && avs_byteenable[0])
        simVal_q <= avs_writedata[`DIC_NCH-1:0];
      if (hitSimCfg && avs_byteenable[1])
        simStat_q <= avs_writedata[`DIC_SIMSTAT_LSB+:`DIC_NCH];
      if (hitErrCfg)
        errCfg_q <= errMerged[2*`DIC_NCH-1:0];
      if (hitSubVal && avs_byteenable[0])
        subVal_q <= wrMerged8[`DIC_NCH-1:0];
    end
  end

  // per-channel delay registers and conditioning chain
  genvar ch;
  generate
    for (ch = 0; ch < `DIC_NCH; ch++)
    begin : g_ch
      // write selects and merged delay words
      wire onSel  = wrCommit & wordAlign & hitOnDly  & (dlyIdx == 3'(ch));
      wire offSel = wrCommit & wordAlign & hitOffDly & (dlyIdx == 3'(ch));
      wire [31:0] onMerged  = beMerge({16'h0000, onDly_q[ch]},  avs_writedata, avs_byteenable);
      wire [31:0] offMerged = beMerge({16'h0000, offDly_q[ch]}, avs_writedata, avs_byteenable);
      dic_err_mode_t errMode;
      wire useSub;
      wire useHold;
      wire faultVal;

      // delay settings take effect on the next filter decision
      // 16-bit ms counts; upper lanes ignored
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          onDly_q[ch]  <= `DIC_RST_DLY;
          offDly_q[ch] <= `DIC_RST_DLY;
        end
        else
        begin
          if (onSel)
            onDly_q[ch] <= onMerged[`DIC_DLY_W-1:0];
          if (offSel)
            offDly_q[ch] <= offMerged[`DIC_DLY_W-1:0];
        end
      end

      // negation first, so delays act on the delivered polarity
      assign invIn[ch] = fieldIn[ch] ^ invert_q[ch];

      dic_delay_filter u_filt
      (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .msTick   (msTick),
        .rawIn    (invIn[ch]),
        .onDelay  (onDly_q[ch]),
        .offDelay (offDly_q[ch]),
        .filtOut  (filt[ch])
      );

      // monitoring off means the front end flags are ignored
      assign fault[ch] = monEn_q[ch] & (lineBreak[ch] | lineShort[ch]);

      // unknown strategy code behaves as pass-live
      assign errMode  = dic_err_mode_t'(errCfg_q[2*ch+:2]);
      assign useSub   = fault[ch] & (errMode == DIC_ERR_SUBST);
      assign useHold  = fault[ch] & (errMode == DIC_ERR_HOLD);
      // live value also stays live under a fault with pass-live strategy
      assign faultVal = useSub  ? subVal_q[ch] :
                        useHold ? lastValid_q[ch] :
                        filt[ch];

      // simulation wins over everything from the field
      assign selVal[ch]   = simEn_q[ch] ? simVal_q[ch] : faultVal;
      assign selValid[ch] = simEn_q[ch] ? simStat_q[ch] : ~fault[ch];
      assign selFault[ch] = ~simEn_q[ch] & fault[ch];

      // value in even bit, fault in odd bit; channels 5-8 form the high byte
      assign telegramNext[2*ch]   = selVal[ch];
      assign telegramNext[2*ch+1] = selFault[ch];

      // enable only reports; data still flows
      assign chanActive[ch] = modEn_q;
    end
  endgenerate

  // last valid value tracks the filtered input only while healthy
  // limitation: a change pending in the filter is lost
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      lastValid_q <= `DIC_RST_CFG8;
    else
      lastValid_q <= (lastValid_q & fault) | (filt & ~fault);
  end

  // periodic delivery; host sees a fresh image once per period only
  // faults skip the filters, shown next period
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      procValue_q      <= `DIC_RST_CFG8;
      procValid_q      <= `DIC_RST_CFG8;
      procFault_q      <= `DIC_RST_CFG8;
      telegram_q       <= `DIC_RST_ERRCFG;
      telegramStrobe_q <= 1'b0;
    end
    else
    begin
      telegramStrobe_q <= updTick;
      if (updTick)
      begin
        procValue_q <= selVal;
        procValid_q <= selValid;
        procFault_q <= selFault;
        telegram_q  <= telegramNext;
      end
    end
  end

  // data outputs straight from registers
  assign procValue      = procValue_q;
  assign procValid      = procValid_q;
  assign procFault      = procFault_q;
  assign telegram       = telegram_q;
  assign telegramStrobe = telegramStrobe_q;
endmodule

// *** verification/dic_cond_asserts.sv ***
// timing and packing checks on the conditioner ports
// assumes binding to dic_conditioner, one clock, synchronous reset
`timescale 1ns/10ps
`include "dic_params.svh"
module dic_cond_asserts
#(
  parameter int UPD_CYCLES = 50
)
(
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic                 avs_waitrequest,
  input wire logic [`DIC_NCH-1:0]   procValue,
  input wire logic [`DIC_NCH-1:0]   procValid,
  input wire logic [`DIC_NCH-1:0]   procFault,
  input wire logic [`DIC_NCH-1:0]   chanActive,
  input wire logic [2*`DIC_NCH-1:0] telegram,
  input wire logic                 telegramStrobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [15:0] expTele;  // value and fault bits interleaved
  logic [15:0] gapCnt_q; // cycles since the last strobe
  logic        seen_q;   // a first strobe has passed
  // expected telegram built from the delivered outputs
  always_comb
  begin
    for (int i = 0; i < `DIC_NCH; i++)
    begin
      expTele[2*i]   = procValue[i];
      expTele[2*i+1] = procFault[i];
    end
  end
  // gap counter; a counter avoids a long repetition
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      gapCnt_q <= 16'h0000;
      seen_q   <= 1'b0;
    end
    else
    begin
      gapCnt_q <= telegramStrobe ? 16'h0001 : gapCnt_q + 16'h0001;
      seen_q   <= seen_q | telegramStrobe;
    end
  end
  a_active_common: assert property (chanActive == {`DIC_NCH{chanActive[0]}})
    else $error("channel active bits disagree");
  a_tele_layout: assert property (telegram == expTele)
    else $error("telegram packing wrong");
  a_fault_invalid: assert property ((procFault & procValid) == 8'h00)
    else $error("faulted channel reported good");
  a_strobe_single: assert property (telegramStrobe |=> !telegramStrobe)
    else $error("strobe longer than one cycle");
  a_strobe_period: assert property (telegramStrobe && seen_q |-> gapCnt_q == 16'(UPD_CYCLES))
    else $error("delivery period wrong");
  a_strobe_due: assert property (seen_q |-> gapCnt_q <= 16'(UPD_CYCLES))
    else $error("delivery overdue");
  a_outputs_hold: assert property ($changed({procValue, procValid, procFault}) && !$past(sys_rst) |-> telegramStrobe)
    else $error("outputs changed between deliveries");
  a_reset_clear: assert property (disable iff (1'b0) sys_rst |=> {procValue, procFault, procValid} == 24'h0 && !telegramStrobe)
    else $error("reset left outputs set");
  a_wait_one: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  cover property (telegramStrobe && procFault != 8'h00);
  cover property (telegramStrobe && procValid != 8'hFF);
  cover property (avs_read && !avs_waitrequest);
  cover property (chanActive == 8'h00);
endmodule
bind dic_conditioner dic_cond_asserts #(.UPD_CYCLES(UPD_CYCLES)) i_dic_cond_asserts
(
  .clk(clk), .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .procValue(procValue), .procValid(procValid),
  .procFault(procFault), .chanActive(chanActive), .telegram(telegram), .telegramStrobe(telegramStrobe)
);

// *** verification/dic_comm_unit.sv ***
// backplane communication unit model: takes each delivered telegram
// assumes telegramStrobe is a one-cycle pulse beside a stable telegram
`timescale 1ns/10ps
module dic_comm_unit
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clrOr,
  input  wire logic [15:0] telegram,
  input  wire logic        telegramStrobe,
  output logic      [15:0] rxTele_q,
  output logic      [15:0] rxOr_q,
  output logic      [15:0] rxCount_q
);
  // or of all telegrams keeps a single short high visible
  always_ff @(posedge clk)
  begin
    if (sys_rst || clrOr)
    begin
      rxOr_q    <= 16'h0000;
      rxCount_q <= 16'h0000;
    end
    else if (telegramStrobe)
    begin
      rxTele_q  <= telegram;
      rxOr_q    <= rxOr_q | telegram;
      rxCount_q <= rxCount_q + 16'h0001;
    end
  end
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the channel conditioner
// assumes design files, checker and comm unit model compile first
`timescale 1ns/10ps
`include "dic_params.svh"
module testbench;
  import dic_pkg::*;
  typedef struct packed
  {
    logic [7:0]  monEn, inv, simEn, simVal, simGood, subVal, fld, brk;
    logic [15:0] errCfg;
    logic [7:0]  expV, expOk, expF;
  } dic_row_t;
  // monEn inv simEn simVal simGood subVal fld brk errCfg | value valid fault
  localparam dic_row_t ROWS [6] = '{
    '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA5, 8'h00, 16'h0000, 8'hA5, 8'hFF, 8'h00},
    '{8'hFF, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA5, 8'h00, 16'h0000, 8'hAA, 8'hFF, 8'h00},
    '{8'hFF, 8'h00, 8'hF0, 8'h30, 8'hC0, 8'h00, 8'h0F, 8'h80, 16'h0000, 8'h3F, 8'hCF, 8'h00},
    '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'hF0, 8'h33, 16'h5555, 8'hC3, 8'hCC, 8'h33},
    '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'hF0, 8'h33, 16'hAA00, 8'hF0, 8'hCC, 8'h33},
    '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'hF0, 8'h33, 16'h5555, 8'hF0, 8'hFF, 8'h00}
  };
  logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest, telegramStrobe, clrOr;
  logic [7:0]  avs_address, fieldIn, lineBreak, lineShort, procValue, procValid, procFault, chanActive;
  logic [31:0] avs_writedata, avs_readdata;
  logic [15:0] telegram, rxTele, rxOr, rxCount;
  int          error_cnt, cmp_count, cycles;
  dic_conditioner #(.MS_CYCLES(10), .UPD_CYCLES(50)) i_dic_conditioner
  (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fieldIn(fieldIn),
    .lineBreak(lineBreak), .lineShort(lineShort), .procValue(procValue), .procValid(procValid),
    .procFault(procFault), .chanActive(chanActive), .telegram(telegram), .telegramStrobe(telegramStrobe)
  );
  dic_comm_unit i_dic_comm_unit
  (
    .clk(clk), .sys_rst(sys_rst), .clrOr(clrOr), .telegram(telegram), .telegramStrobe(telegramStrobe),
    .rxTele_q(rxTele), .rxOr_q(rxOr), .rxCount_q(rxCount)
  );
  // free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, far above the expected run length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // expected telegram: value in even bit, fault in odd bit
  function automatic logic [15:0] teleOf(input logic [7:0] v, input logic [7:0] f);
    for (int i = 0; i < 8; i++)
      teleOf[2*i+:2] = {f[i], v[i]};
  endfunction
  // one transfer, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // wait for k deliveries, no bound of its own; only the hang guard catches a stall
  task automatic frames(input int k);
    repeat (k)
    begin
      do
        @(negedge clk);
      while (telegramStrobe !== 1'b1);
    end
  endtask
  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    fieldIn = 8'h00;
    lineBreak = 8'h00;
    lineShort = 8'h00;
    clrOr = 1'b0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk({procValue, procValid, procFault}, 32'h0);
    chk(chanActive, 8'hFF);
    rdc(`DIC_ADDR_MONEN, 32'hFF);
    rdc(`DIC_ADDR_ONDLY, 32'h0);
    wr(8'h30, 32'hFFFFFFFF);
    rdc(8'h30, 32'h0);
    wr(`DIC_ADDR_CTRL, 32'h0);
    @(negedge clk);
    chk(chanActive, 8'h00);
    wr(`DIC_ADDR_CTRL, 32'h1);
    // table rows: configure, drive, then compare after two deliveries
    foreach (ROWS[r])
    begin
      wr(`DIC_ADDR_MONEN, {24'h0, ROWS[r].monEn});
      wr(`DIC_ADDR_INVERT, {24'h0, ROWS[r].inv});
      wr(`DIC_ADDR_SIMEN, {24'h0, ROWS[r].simEn});
      wr(`DIC_ADDR_SIMCFG, {16'h0, ROWS[r].simGood, ROWS[r].simVal});
      wr(`DIC_ADDR_ERRCFG, {16'h0, ROWS[r].errCfg});
      wr(`DIC_ADDR_SUBVAL, {24'h0, ROWS[r].subVal});
      fieldIn   <= ROWS[r].fld;
      lineBreak <= ROWS[r].brk;
      frames(2);
      chk(procValue, ROWS[r].expV);
      chk(procValid, ROWS[r].expOk);
      chk(procFault, ROWS[r].expF);
      chk(telegram, teleOf(ROWS[r].expV, ROWS[r].expF));
      @(negedge clk);
      chk(rxTele, teleOf(ROWS[r].expV, ROWS[r].expF));
      rdc(`DIC_ADDR_STATUS, {8'hFF, ROWS[r].expF, ROWS[r].expOk, ROWS[r].expV});
    end
    // hold strategy: fault and field change on the same edge
    wr(`DIC_ADDR_MONEN, 32'hFF);
    wr(`DIC_ADDR_ERRCFG, 32'hFFFF);
    fieldIn   <= 8'hF0;
    lineBreak <= 8'h00;
    frames(2);
    @(posedge clk);
    fieldIn   <= 8'h0F;
    lineShort <= 8'hFF;
    frames(2);
    chk({procValue, procValid, procFault}, 32'hF000FF);
    @(posedge clk);
    lineShort <= 8'h00;
    frames(2);
    chk({procValue, procValid}, 32'h0FFF);
    // short high on channel 1 against an 8 ms on-delay
    wr(`DIC_ADDR_ERRCFG, 32'h0);
    wr(`DIC_ADDR_ONDLY, 32'h8);
    fieldIn <= 8'h00;
    frames(2);
    @(posedge clk);
    clrOr   <= 1'b1;
    fieldIn <= 8'h01;
    @(posedge clk);
    clrOr <= 1'b0;
    repeat (59) @(posedge clk);
    fieldIn <= 8'h00;
    frames(3);
    chk(rxOr[0], 1'b0);
    chk(rxCount >= 16'h0003, 1'b1);
    @(posedge clk);
    fieldIn <= 8'h01;
    frames(4);
    chk(procValue, 8'h01);
    // channel 2 falling edge stretched by an 8 ms off-delay
    wr(`DIC_ADDR_OFFDLY + 8'h04, 32'h8);
    fieldIn <= 8'h03;
    frames(2);
    @(posedge clk);
    fieldIn <= 8'h01;
    frames(1);
    chk(procValue, 8'h03);
    frames(3);
    chk(procValue, 8'h01);
    // reset in mid-run
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk({procValue, procValid, procFault}, 32'h0);
    rdc(`DIC_ADDR_ONDLY, 32'h0);
    wrap_up();
  end
endmodule
